// ### pkg/tsw_cfg.svh
// Purpose: shared constants of the time-slot switch device and host ends
// Assumes: 40 MHz system clock
// Notes: every offset, flag bit and timing count lives here
`ifndef TSW_CFG_SVH
`define TSW_CFG_SVH

// timing
`define TSW_CLK_KHZ 40000
`define TSW_IN_CLK_KHZ 8192
`define TSW_RST_HOLD_IN_CLKS 2
`define TSW_RST_HOLD_CYC ((`TSW_RST_HOLD_IN_CLKS * `TSW_CLK_KHZ + `TSW_IN_CLK_KHZ - 1) / `TSW_IN_CLK_KHZ)
`define TSW_SETTLE_US 250
`define TSW_SETTLE_CYC (`TSW_SETTLE_US * `TSW_CLK_KHZ / 1000)

// stream geometry and memories
`define TSW_CHANNELS 512
`define TSW_STREAMS 8
`define TSW_MEM_WORDS 4096
`define TSW_PAGES 3
`define TSW_LAST_CH 9'h1ff
`define TSW_LAST_BIT 3'h7

// host port of the device
`define TSW_MEM_SEL_BIT 14
`define TSW_REG_CTRL 14'h0000
`define TSW_REG_STATUS 14'h0001
`define TSW_CTRL_RESET 16'h0000
`define TSW_CTRL_OSB_BIT 0
`define TSW_CTRL_MS_LSB 1
`define TSW_MS_LCM 3'h0
`define TSW_MS_BCM 3'h1
`define TSW_MS_LDM 3'h2
`define TSW_MS_BDM 3'h3

// connection memory word
`define TSW_CM_SRC_BIT 15
`define TSW_CM_MSG_BIT 14
`define TSW_CM_OE_BIT 13

// host controller registers on AXI4-Lite
`define TSW_AXI_CTRL 5'h00
`define TSW_AXI_ADDR 5'h04
`define TSW_AXI_WDATA 5'h08
`define TSW_AXI_CMD 5'h0c
`define TSW_AXI_STATUS 5'h10
`define TSW_HCTRL_ODE_BIT 0
`define TSW_HCTRL_RST_BIT 1
`define TSW_HCMD_READ_BIT 0
`define TSW_HSTAT_BUSY_BIT 0
`define TSW_HSTAT_READY_BIT 1

`endif

// ### pkg/tsw_if.sv
// Purpose: host port pins between the controller and the switch device
// Assumes: both ends run on the same clock
// Notes: the shared data bus and the open-drain acknowledge are resolved here
`default_nettype none
interface tsw_if;
  logic [14:0] addr;
  logic [15:0] hostData;
  logic hostDataOe;
  logic [15:0] devData;
  logic devDataOe;
  logic csN;
  logic dsN;
  logic rw;
  logic dtaOe;
  logic resetN;
  logic output_drive_enable_pin;
  logic testReset;
  logic [15:0] dataBus;
  logic transferAckN;

  // undriven bus floats high through pull-ups
  assign dataBus = hostDataOe ? hostData : (devDataOe ? devData : 16'hffff);
  assign transferAckN = ~dtaOe;

  modport device (
    input addr, dataBus, csN, dsN, rw, resetN, output_drive_enable_pin,
    output devData, devDataOe, dtaOe
  );
  modport host (
    input dataBus, transferAckN,
    output addr, hostData, hostDataOe, csN, dsN, rw, resetN, output_drive_enable_pin, testReset
  );
endinterface
`default_nettype wire

// ### pkg/tsw_pkg.sv
// Purpose: state types of the time-slot switch ends
// Assumes: constants come from tsw_cfg.svh
// Notes: device and host keep their register state in one packed struct each; memories and synchronisers stay outside
`default_nettype none
package tsw_pkg;

  typedef enum logic {
    DEV_IDLE = 1'b0,
    DEV_ACK = 1'b1
  } tsw_dev_hp_t;

  typedef enum logic [2:0] {
    H_RST_HOLD = 3'b000,
    H_RST_ALIGN = 3'b001,
    H_SETTLE = 3'b010,
    H_IDLE = 3'b011,
    H_STROBE = 3'b100,
    H_RELEASE = 3'b101
  } tsw_host_ph_t;

  typedef struct packed {
    tsw_dev_hp_t hpState;
    logic [15:0] ctrl;
    logic [15:0] rdData;
    logic dataOe;
    logic dtaOe;
    logic [1:0] rstSync;
    logic [1:0] mode;
    logic [11:0] cnt;
    logic [1:0] page;
    logic [1:0][7:0][7:0] inSh;
    logic [1:0][7:0][7:0] outSh;
    logic [1:0][7:0] chEn;
    logic [1:0][7:0] outBit;
    logic [1:0][7:0] outOe;
  } tsw_dev_st_t;

  typedef struct packed {
    tsw_host_ph_t phase;
    logic [13:0] cnt;
    logic ctrlOde;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic doRead;
    logic resetN;
    logic output_drive_enable_pin;
    logic csN;
    logic dsN;
    logic rw;
    logic dataOe;
    logic awReady;
    logic wReady;
    logic awHeld;
    logic wHeld;
    logic [4:0] awAddr;
    logic [31:0] wData;
    logic bValid;
    logic arReady;
    logic rValid;
    logic [31:0] rData;
  } tsw_host_st_t;

endpackage
`default_nettype wire

// ### src/tsw_device.sv
// Purpose: switch device end: serial switching, output control, host port
// Assumes: one serial bit per enabled clock, frame pulse marks bit 0
// Notes: Behaviour
// Behaviour
// - mode pin low drives channels two-state
// - mode high, channel enable low gives hi-Z
// - mode pins captured in the two cycles after reset release
// - priority reset, drive-enable, standby, channel enable
// - reset forces outputs and clears registers
// - drive-enable low forces both ports off
// - input channels stored by stream and channel
// - frame N data leaves in frame N+2
// - offsets never change frame delay
// - 512 channels, delay two frames plus n-m
// - non-multiplexed 16-bit data, 15-bit address port
// - four 4096-word memories, address bit 14 plus control field select
// - connection memories read-write, data memories read-only
// - acknowledge completes even without master clock
// - reset asserts and releases asynchronously, rstSync holds outputs two cycles
// - host holds reset two input clocks
// - host waits 250 us before first access
// - reset release avoids 12-13 us window
// - reset release aligned to frame pulse
// - drive-enable raised only after memory setup
// - test reset held low always
// - word bits 14,13 select message and enable
`include "tsw_cfg.svh"
`default_nettype none
module tsw_device (
  // system
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  // host port pins
  tsw_if.device hp,
  // straps and frame timing
  input wire logic localTristateModePin,
  input wire logic backplaneTristateModePin,
  input wire logic masterFramePulse,
  // serial inputs
  input wire logic [7:0] localSerialInputs,
  input wire logic [7:0] backplaneSerialInputs,
  // serial outputs
  output logic [7:0] localSerialOutputs,
  output logic [7:0] localSerialOe,
  output logic [7:0] backplaneSerialOutputs,
  output logic [7:0] backplaneSerialOe
);
  import tsw_pkg::*;

  tsw_dev_st_t st_r;
  tsw_dev_st_t st_nxt;
  logic [15:0] connMem [2][`TSW_MEM_WORDS];
  logic [7:0] dataMem [2][`TSW_PAGES][`TSW_MEM_WORDS];

  logic [21:0] syncIn;
  logic [21:0] syncOut;
  logic devRst;
  logic odeS;
  logic csNS;
  logic dsNS;
  logic fpS;
  logic [1:0] modeS;
  logic [1:0][7:0] serS;
  logic [11:0] cur;
  logic [1:0] curPage;
  logic [1:0] rdPage;
  logic [1:0] oldPage;
  logic [8:0] nch;
  logic [15:0] cmWord;
  logic srcLocal;
  logic forceOff;
  logic [11:0] hpIdx;
  logic [2:0] memSel;
  logic cmWe;
  logic [15:0] hostRead;

  function automatic logic [1:0] pageInc(input logic [1:0] x);
    pageInc = (x == 2'h2) ? 2'h0 : x + 2'h1;
  endfunction

  // reset asserts and releases at once; rstSync holds outputs forced two cycles more
  assign devRst = rst | ~hp.resetN;

  // strobes enter inverted so a cleared synchroniser reads as idle;
  // the stages run through a device reset so the strap capture sees pins
  assign syncIn = {hp.output_drive_enable_pin, ~hp.csN, ~hp.dsN, masterFramePulse,
                   backplaneTristateModePin, localTristateModePin,
                   backplaneSerialInputs, localSerialInputs};
  tsw_sync #(.WIDTH(22)) u_sync (
    .clock(clock),
    .rst(rst),
    .clockEn(clockEn),
    .d(syncIn),
    .q(syncOut)
  );
  assign odeS = syncOut[21];
  assign csNS = ~syncOut[20];
  assign dsNS = ~syncOut[19];
  assign fpS = syncOut[18];
  assign modeS = syncOut[17:16];
  assign serS = syncOut[15:0];

  always_comb begin
    st_nxt = st_r;
    cmWord = 16'h0000;
    srcLocal = 1'b0;
    forceOff = 1'b0;
    cmWe = 1'b0;
    hostRead = 16'h0000;
    st_nxt.rstSync = {st_r.rstSync[0], 1'b0};
    if (st_r.rstSync[1]) begin
      st_nxt.mode = modeS;
    end
    // frame counter, page rotates at every frame start
    cur = fpS ? 12'h000 : st_r.cnt;
    curPage = (cur == 12'h000) ? pageInc(st_r.page) : st_r.page;
    st_nxt.cnt = cur + 12'h001;
    st_nxt.page = curPage;
    nch = cur[11:3] + 9'h001;
    // page written two frames before the channel being loaded
    rdPage = (cur[11:3] == `TSW_LAST_CH) ? pageInc(pageInc(curPage))
                                         : pageInc(curPage);
    oldPage = pageInc(pageInc(st_r.page));
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < `TSW_STREAMS; s++) begin
        st_nxt.inSh[p][s] = {st_r.inSh[p][s][6:0], serS[p][s]};
        if (cur[2:0] == `TSW_LAST_BIT) begin
          cmWord = connMem[p][{3'(s), nch}];
          srcLocal = (p == 0) ? cmWord[`TSW_CM_SRC_BIT]
                              : ~cmWord[`TSW_CM_SRC_BIT];
          if (cmWord[`TSW_CM_MSG_BIT]) begin
            st_nxt.outSh[p][s] = cmWord[7:0];
          end else if (srcLocal) begin
            st_nxt.outSh[p][s] = dataMem[0][rdPage][cmWord[11:0]];
          end else begin
            st_nxt.outSh[p][s] = dataMem[1][rdPage][cmWord[11:0]];
          end
          st_nxt.chEn[p][s] = cmWord[`TSW_CM_OE_BIT];
        end else begin
          st_nxt.outSh[p][s] = {st_r.outSh[p][s][6:0], 1'b1};
        end
        forceOff = st_r.rstSync[1] | ~odeS | ~st_r.ctrl[`TSW_CTRL_OSB_BIT]
                   | ~st_nxt.chEn[p][s];
        st_nxt.outBit[p][s] = forceOff ? 1'b1 : st_nxt.outSh[p][s][7];
        st_nxt.outOe[p][s] = forceOff ? ~st_nxt.mode[p] : 1'b1;
      end
    end
    // host port
    hpIdx = hp.addr[11:0];
    memSel = st_r.ctrl[`TSW_CTRL_MS_LSB +: 3];
    if (hp.addr[`TSW_MEM_SEL_BIT]) begin
      unique case (memSel)
        `TSW_MS_LCM: hostRead = connMem[0][hpIdx];
        `TSW_MS_BCM: hostRead = connMem[1][hpIdx];
        `TSW_MS_LDM: hostRead = {8'h00, dataMem[0][oldPage][hpIdx]};
        `TSW_MS_BDM: hostRead = {8'h00, dataMem[1][oldPage][hpIdx]};
        default: hostRead = 16'h0000;
      endcase
    end else if (hp.addr[13:0] == `TSW_REG_CTRL) begin
      hostRead = st_r.ctrl;
    end else if (hp.addr[13:0] == `TSW_REG_STATUS) begin
      hostRead = {2'h0, st_r.page, st_r.cnt};
    end
    // handshake runs on the system clock, with or without frames
    unique case (st_r.hpState)
      DEV_IDLE: begin
        if (!csNS && !dsNS) begin
          st_nxt.hpState = DEV_ACK;
          st_nxt.dtaOe = 1'b1;
          st_nxt.dataOe = hp.rw;
          st_nxt.rdData = hostRead;
          if (!hp.rw && hp.addr[`TSW_MEM_SEL_BIT]) begin
            // data memories ignore host writes
            cmWe = (memSel == `TSW_MS_LCM) || (memSel == `TSW_MS_BCM);
          end else if (!hp.rw && hp.addr[13:0] == `TSW_REG_CTRL) begin
            st_nxt.ctrl = hp.dataBus;
          end
        end
      end
      DEV_ACK: begin
        if (dsNS) begin
          st_nxt.hpState = DEV_IDLE;
          st_nxt.dtaOe = 1'b0;
          st_nxt.dataOe = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge devRst) begin
    if (devRst) begin
      st_r <= '{hpState: DEV_IDLE, ctrl: `TSW_CTRL_RESET, rstSync: 2'b11,
                outBit: 16'hffff, default: '0};
    end else if (clockEn) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (clockEn) begin
      if (cmWe) begin
        connMem[memSel[0]][hpIdx] <= hp.dataBus;
      end
      if (cur[2:0] == `TSW_LAST_BIT) begin
        for (int p = 0; p < 2; p++) begin
          for (int s = 0; s < `TSW_STREAMS; s++) begin
            dataMem[p][curPage][{3'(s), cur[11:3]}] <= st_nxt.inSh[p][s];
          end
        end
      end
    end
  end

  assign localSerialOutputs = st_r.outBit[0];
  assign localSerialOe = st_r.outOe[0];
  assign backplaneSerialOutputs = st_r.outBit[1];
  assign backplaneSerialOe = st_r.outOe[1];
  assign hp.devData = st_r.rdData;
  assign hp.devDataOe = st_r.dataOe;
  assign hp.dtaOe = st_r.dtaOe;
endmodule
`default_nettype wire

// ### src/tsw_host.sv
// Purpose: host end: drives reset, drive-enable and the switch host port
// Assumes: software orders accesses over AXI4-Lite
// Notes: one port access at a time, refused while busy or settling
`include "tsw_cfg.svh"
`default_nettype none
module tsw_host #(
  parameter int SETTLE_CYCLES = `TSW_SETTLE_CYC
) (
  // system
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  // switch pins
  tsw_if.host hp,
  input wire logic masterFramePulse,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  import tsw_pkg::*;

  tsw_host_st_t st_r;
  tsw_host_st_t st_nxt;
  logic [1:0] syncOut;
  logic ackS;
  logic fpS;
  logic ready;

  tsw_sync #(.WIDTH(2)) u_sync (
    .clock(clock),
    .rst(rst),
    .clockEn(clockEn),
    .d({~hp.transferAckN, masterFramePulse}),
    .q(syncOut)
  );
  assign ackS = syncOut[1];
  assign fpS = syncOut[0];
  assign ready = st_r.phase == H_IDLE;

  always_comb begin
    st_nxt = st_r;
    // write channel: address and data taken in either order
    if (awvalid && st_r.awReady) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid && st_r.wReady) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = wdata;
    end
    if (st_r.bValid && bready) begin
      st_nxt.bValid = 1'b0;
    end
    if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld = 1'b0;
      st_nxt.bValid = 1'b1;
      if (|wstrb || 1'b1) begin
        unique case (st_r.awAddr)
          `TSW_AXI_CTRL: begin
            st_nxt.ctrlOde = st_r.wData[`TSW_HCTRL_ODE_BIT];
            if (st_r.wData[`TSW_HCTRL_RST_BIT]) begin
              st_nxt.phase = H_RST_HOLD;
              st_nxt.cnt = 14'h0000;
            end
          end
          `TSW_AXI_ADDR: st_nxt.addr = st_r.wData[14:0];
          `TSW_AXI_WDATA: st_nxt.wdata = st_r.wData[15:0];
          `TSW_AXI_CMD: begin
            if (ready) begin
              st_nxt.phase = H_STROBE;
              st_nxt.doRead = st_r.wData[`TSW_HCMD_READ_BIT];
            end
          end
          default: ;
        endcase
      end
    end
    st_nxt.awReady = !st_nxt.awHeld && !st_nxt.bValid;
    st_nxt.wReady = !st_nxt.wHeld && !st_nxt.bValid;
    // read channel
    if (st_r.rValid && rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (arvalid && st_r.arReady) begin
      st_nxt.rValid = 1'b1;
      unique case (araddr)
        `TSW_AXI_CTRL: st_nxt.rData = {31'h0, st_r.ctrlOde};
        `TSW_AXI_ADDR: st_nxt.rData = {17'h0, st_r.addr};
        `TSW_AXI_WDATA: st_nxt.rData = {16'h0, st_r.wdata};
        `TSW_AXI_STATUS: st_nxt.rData = {st_r.rdata, 14'h0, ready,
                                         st_r.phase == H_STROBE
                                         || st_r.phase == H_RELEASE};
        default: st_nxt.rData = 32'h0;
      endcase
    end
    st_nxt.arReady = !st_nxt.rValid;
    // pin sequencer
    unique case (st_r.phase)
      H_RST_HOLD: begin
        st_nxt.resetN = 1'b0;
        st_nxt.cnt = st_r.cnt + 14'h0001;
        if (st_r.cnt >= 14'(`TSW_RST_HOLD_CYC - 1)) begin
          st_nxt.phase = H_RST_ALIGN;
        end
      end
      H_RST_ALIGN: begin
        if (fpS) begin
          st_nxt.resetN = 1'b1;
          st_nxt.cnt = 14'h0000;
          st_nxt.phase = H_SETTLE;
        end
      end
      H_SETTLE: begin
        st_nxt.cnt = st_r.cnt + 14'h0001;
        if (st_r.cnt >= 14'(SETTLE_CYCLES - 1)) begin
          st_nxt.phase = H_IDLE;
        end
      end
      H_IDLE: ;
      H_STROBE: begin
        st_nxt.csN = 1'b0;
        st_nxt.dsN = 1'b0;
        st_nxt.rw = st_r.doRead;
        st_nxt.dataOe = !st_r.doRead;
        if (ackS) begin
          st_nxt.csN = 1'b1;
          st_nxt.dsN = 1'b1;
          st_nxt.dataOe = 1'b0;
          st_nxt.phase = H_RELEASE;
          if (st_r.doRead) begin
            st_nxt.rdata = hp.dataBus;
          end
        end
      end
      H_RELEASE: begin
        if (!ackS) begin
          st_nxt.phase = H_IDLE;
        end
      end
      default: st_nxt.phase = H_IDLE;
    endcase
    // drive-enable stays low until reset and settling are over
    st_nxt.output_drive_enable_pin = st_nxt.ctrlOde && st_nxt.resetN
                 && st_nxt.phase != H_SETTLE;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '{phase: H_RST_HOLD, csN: 1'b1, dsN: 1'b1, rw: 1'b1,
                default: '0};
    end else if (clockEn) begin
      st_r <= st_nxt;
    end
  end

  assign hp.addr = st_r.addr;
  assign hp.hostData = st_r.wdata;
  assign hp.hostDataOe = st_r.dataOe;
  assign hp.csN = st_r.csN;
  assign hp.dsN = st_r.dsN;
  assign hp.rw = st_r.rw;
  assign hp.resetN = st_r.resetN;
  assign hp.output_drive_enable_pin = st_r.output_drive_enable_pin;
  assign hp.testReset = 1'b0;
  assign awready = st_r.awReady;
  assign wready = st_r.wReady;
  assign bvalid = st_r.bValid;
  assign bresp = 2'b00;
  assign arready = st_r.arReady;
  assign rvalid = st_r.rValid;
  assign rdata = st_r.rData;
  assign rresp = 2'b00;
endmodule
`default_nettype wire

// ### src/tsw_sync.sv
// Purpose: two-flop synchroniser for a bundle of unrelated levels
// Assumes: each bit is an independent level
// Notes: only the second stage is visible outside
`include "tsw_cfg.svh"
`default_nettype none
module tsw_sync #(
  parameter int WIDTH = 1
) (
  // system
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEn,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import tsw_pkg::*;
  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          meta_r[i] <= 1'b0;
          q[i] <= 1'b0;
        end else if (clockEn) begin
          meta_r[i] <= d[i];
          q[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### testbench/tb_tdm_switch_output_enable_reset.sv
// Purpose: drives both switch ends by software orders and serial data
// Assumes: frame of 4096 clocks, one bit per clock, 40 MHz
// Notes: settle wait shortened; outputs sampled mid-channel
`include "tsw_cfg.svh"
`default_nettype none
module tb_tdm_switch_output_enable_reset;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  localparam int LIMIT = 6000;
  logic clock = 1'b0, rst = 1'b1, localMode = 1'b0, bpMode = 1'b1;
  logic masterFramePulse = 1'b0;
  logic [7:0] localIn = 8'h00;
  logic [11:0] slot = 12'hfff;
  logic [11:0] nxtSlot;
  int frameNo = 0;
  int nxtFrame;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] rdata;
  logic [7:0] lOut, lOe, bOut, bOe;
  int failCount = 0;
  int totalChecks = 0;

  tsw_if hpIf();
  tsw_host #(.SETTLE_CYCLES(SETTLE)) i_tsw_host (
    .clock(clock), .rst(rst), .clockEn(1'b1), .hp(hpIf),
    .masterFramePulse(masterFramePulse),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp()
  );
  tsw_device i_tsw_device (
    .clock(clock), .rst(rst), .clockEn(1'b1), .hp(hpIf),
    .localTristateModePin(localMode), .backplaneTristateModePin(bpMode),
    .masterFramePulse(masterFramePulse),
    .localSerialInputs(localIn), .backplaneSerialInputs(8'h00),
    .localSerialOutputs(lOut), .localSerialOe(lOe),
    .backplaneSerialOutputs(bOut), .backplaneSerialOe(bOe)
  );
  tsw_chk #(.SETTLE_CYCLES(SETTLE)) i_tsw_chk (
    .clock(clock), .rst(rst), .csN(hpIf.csN), .dsN(hpIf.dsN), .rw(hpIf.rw),
    .dtaOe(hpIf.dtaOe), .devDataOe(hpIf.devDataOe),
    .hostDataOe(hpIf.hostDataOe), .resetN(hpIf.resetN), .output_drive_enable_pin(hpIf.output_drive_enable_pin),
    .testReset(hpIf.testReset)
  );

  always #12.5 clock = ~clock;

  function automatic logic patBit(input int f);
    return f[1];
  endfunction

  // stream 0 channel 3 carries a byte whose bits all follow the frame
  assign nxtSlot = slot + 12'h001;
  assign nxtFrame = frameNo + int'(slot == 12'hfff);
  always @(posedge clock) begin
    slot <= nxtSlot;
    frameNo <= nxtFrame;
    masterFramePulse <= (nxtSlot == 12'h000);
    localIn <= {7'h00, nxtSlot[11:3] == 9'h003 && patBit(nxtFrame)};
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    totalChecks++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic bail(input string what);
    failCount++;
    $display("CHECK FAILED %0t timeout %s", $time, what);
    results();
  endtask

  task automatic axiW(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < LIMIT);
    bready <= 1'b0;
    if (n >= LIMIT) bail("axi write");
  endtask

  task automatic axiR(input logic [4:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < LIMIT);
    d = rdata;
    rready <= 1'b0;
    if (n >= LIMIT) bail("axi read");
  endtask

  task automatic waitReady();
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      axiR(`TSW_AXI_STATUS, s);
      n++;
    end while (s[`TSW_HSTAT_READY_BIT] !== 1'b1 && n < 3000);
    if (n >= 3000) bail("ready");
  endtask

  // one device access: rd high reads, q returns the read word
  task automatic hpAcc(input logic rd, input logic [14:0] a,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] s;
    waitReady();
    axiW(`TSW_AXI_ADDR, {17'h0, a});
    axiW(`TSW_AXI_WDATA, {16'h0, wd});
    axiW(`TSW_AXI_CMD, {31'h0, rd});
    waitReady();
    axiR(`TSW_AXI_STATUS, s);
    q = s[31:16];
  endtask

  task automatic waitSlot(input logic [11:0] s);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (slot !== s && n < LIMIT);
    if (n >= LIMIT) bail("slot");
  endtask

  // local ch5 is fed from ch3; backplane ch7 sends 00, ch8 is switched off
  task automatic outChk(input logic live);
    logic lExp;
    waitSlot(12'h800);
    waitSlot(12'h02e);
    lExp = live ? patBit(frameNo - 2) : 1'b1;
    chk({31'h0, lOut[0]}, {31'h0, lExp}, "local data");
    chk({31'h0, lOe[0]}, 32'h1, "local drive");
    waitSlot(12'h03e);
    chk({31'h0, bOe[0]}, {31'h0, live}, "message drive");
    if (live) chk({31'h0, bOut[0]}, 32'h0, "message data");
    waitSlot(12'h046);
    chk({31'h0, bOe[0]}, 32'h0, "channel off");
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] q;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    chk({24'h0, lOe}, 32'h0, "reset drive");
    chk({24'h0, lOut}, 32'hff, "reset level");
    waitReady();
    chk({24'h0, lOe}, 32'hff, "two-state");
    chk({24'h0, lOut}, 32'hff, "drive off");
    chk({24'h0, bOe}, 32'h0, "hi-z port");
    axiR(5'h14, r);
    chk(r, 32'h0, "unmapped read");
    hpAcc(1'b0, 15'h0000, 16'h0002, q);
    hpAcc(1'b1, 15'h0000, 16'h0000, q);
    chk({16'h0, q}, 32'h2, "ctrl readback");
    hpAcc(1'b0, 15'h4007, 16'h6000, q);
    hpAcc(1'b0, 15'h4008, 16'h4000, q);
    hpAcc(1'b1, 15'h4008, 16'h0000, q);
    chk({16'h0, q}, 32'h4000, "cm readback");
    hpAcc(1'b0, 15'h0000, 16'h0000, q);
    hpAcc(1'b0, 15'h4005, 16'ha003, q);
    hpAcc(1'b0, 15'h0000, 16'h0001, q);
    outChk(1'b0);
    axiW(`TSW_AXI_CTRL, 32'h1);
    repeat (3) outChk(1'b1);
    // standby on, data memory selected; channel 4 only ever carries zeros
    hpAcc(1'b0, 15'h0000, 16'h0004, q);
    hpAcc(1'b0, 15'h4004, 16'h1234, q);
    hpAcc(1'b1, 15'h4004, 16'h0000, q);
    chk({16'h0, q}, 32'h0, "dm read only");
    outChk(1'b0);
    // software reset in mid-run recaptures the mode straps
    axiW(`TSW_AXI_CTRL, 32'h3);
    waitReady();
    chk({8'h0, lOe, bOe, lOut}, 32'h00ff00ff, "mid-run reset");
    results();
  end
endmodule
`default_nettype wire

// ### testbench/tsw_chk.sv
// Purpose: host port and reset checks on the wires between the two ends
// Assumes: one clock; rst async active high
// Notes: sees the interface signals only
`include "tsw_cfg.svh"
`default_nettype none
module tsw_chk #(
  parameter int SETTLE_CYCLES = `TSW_SETTLE_CYC
) (
  // system
  input wire logic clock,
  input wire logic rst,
  // host port wires
  input wire logic csN,
  input wire logic dsN,
  input wire logic rw,
  input wire logic dtaOe,
  input wire logic devDataOe,
  input wire logic hostDataOe,
  input wire logic resetN,
  input wire logic output_drive_enable_pin,
  input wire logic testReset
);
  timeunit 1ns;
  timeprecision 1ps;
  // the first hold cycle of a software reset does not yet pull reset low
  localparam int HOLD_MIN = `TSW_RST_HOLD_CYC - 1;
  logic [7:0] lowCnt_r;
  logic [15:0] relCnt_r;

  // length of the device reset in progress (cleared on release) and time since its release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lowCnt_r <= 8'h00;
      relCnt_r <= 16'h0000;
    end else if (!resetN) begin
      lowCnt_r <= lowCnt_r + {7'h00, lowCnt_r != 8'hff};
      relCnt_r <= 16'h0000;
    end else begin
      lowCnt_r <= 8'h00;
      relCnt_r <= relCnt_r + {15'h0000, relCnt_r != 16'hffff};
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence strobeStart;
    $fell(dsN) && resetN;
  endsequence
  sequence odeQuiet;
    !output_drive_enable_pin [*8];
  endsequence

  a_ack_delay: assert property (strobeStart |-> ##3 dtaOe)
    else $error("late acknowledge");
  a_ack_drop: assert property ($rose(dsN) |-> ##3 !dtaOe)
    else $error("acknowledge not withdrawn");
  a_ack_cause: assert property ($rose(dtaOe) |-> !csN && !$past(dsN, 3))
    else $error("acknowledge without strobe");
  a_read_data: assert property (dtaOe && rw && !csN |-> devDataOe)
    else $error("read data not driven");
  a_bus_owner: assert property (!(hostDataOe && devDataOe))
    else $error("data bus contention");
  a_reset_quiet: assert property (!resetN |-> !dtaOe && !devDataOe)
    else $error("port active in reset");
  a_reset_width: assert property ($rose(resetN) |-> lowCnt_r >= HOLD_MIN)
    else $error("reset pulse too short");
  a_settle_wait: assert property ($fell(csN) |-> relCnt_r >= SETTLE_CYCLES)
    else $error("access too soon after reset");
  a_ode_quiet: assert property ($rose(resetN) |-> odeQuiet)
    else $error("drive enable raised early");
  a_test_low: assert property (!testReset)
    else $error("test reset raised");
endmodule
`default_nettype wire
